/* File: led_gpio_defs.vh */
// Purpose: constants shared by the led/gpio expander design files
// Assumes: 50 MHz clock, word-wide register port with one-cycle read latency
// Notes: offsets are register indices on the plain register port
`ifndef LED_GPIO_DEFS_VH
`define LED_GPIO_DEFS_VH

`define NUM_IO 6
`define CLK_MHZ 50
// deglitch time in microseconds and its cycle count
`define DEGLITCH_US 8
`define DEGLITCH_CYC (`DEGLITCH_US * `CLK_MHZ)
`define DEGLITCH_W 9

// register indices
`define REG_INPUT 4'h0
`define REG_OUTPUT 4'h1
`define REG_DIR 4'h2
`define REG_MODE 4'h3
`define REG_GLOBAL 4'h4
`define REG_BREATH_EN 4'h5
`define REG_BREATH_SEL 4'h6
`define REG_BREATH_PER 4'h7
`define REG_ADDR 4'h8
`define REG_DIM_BASE 4'h9

// global control fields
`define GLB_FULL_SCALE_CURRENT_LSB 0
`define GLB_FULL_SCALE_CURRENT_W 2
`define GLB_PP_BIT 2

// reset values
// direction bit high means input, so all six come out of reset as outputs
`define RST_DIR 6'h00
// pin level and enable out of reset: high and released, so no led lights
`define RST_PINS 6'h3F
`define RST_MODE 6'h00
`define RST_GLOBAL 8'h00
`define RST_BREATH_PER 8'h10
`define RST_DIM 8'h00

// breathing step prescale: one step per 2^16 clocks times (period plus one)
`define BREATH_PRE_W 16

// breathing effect selection
`define BR_BLINK 1'b0
`define BR_FADE 1'b1

`endif

/* File: deglitch_filter.v */
// Purpose: per-input stability filter
// Assumes: input synchronous to clk
// Notes: a new level is accepted after it stays stable for the deglitch count
`include "led_gpio_defs.vh"
module deglitch_filter (
  input wire clk,
  input wire reset,
  input wire rawIn,
  input wire initLevel,
  output reg stableOut
);
  reg [`DEGLITCH_W-1:0] cnt_reg;

  // counter restarts on every transition away from the accepted level
  always @(posedge clk) begin
    if (reset) begin
      cnt_reg <= {`DEGLITCH_W{1'b0}};
      stableOut <= initLevel; // accepted level out of reset; the top ties initLevel low, so a pin idling high shows a change
    end else if (rawIn == stableOut) begin
      cnt_reg <= {`DEGLITCH_W{1'b0}};
    end else if (cnt_reg == `DEGLITCH_CYC - 1) begin
      stableOut <= rawIn;
      cnt_reg <= {`DEGLITCH_W{1'b0}};
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end
endmodule // deglitch_filter

/* File: led_pwm_channel.v */
// Purpose: one led channel: 8-bit pwm with blink and fade effects
// Assumes: period step derived from shared prescaler tick
// Notes: duty updates only at pwm period boundary to avoid glitches
`include "led_gpio_defs.vh"
module led_pwm_channel (
  input wire clk,
  input wire reset,
  input wire [7:0] dimLevel,
  input wire breathEn,
  input wire breathSel,
  input wire stepTick,
  output reg pwmOut
);
  reg [7:0] phase_reg;
  reg [7:0] duty_reg;
  reg [7:0] fade_reg;
  reg fadeUp_reg;
  reg blink_reg;
  reg [7:0] target;

  // effect level: blink toggles dim/off, fade ramps between 0 and dim
  always @* begin
    if (!breathEn)
      target = dimLevel;
    else if (breathSel == `BR_BLINK)
      target = blink_reg ? dimLevel : 8'h00;
    else
      target = (fade_reg > dimLevel) ? dimLevel : fade_reg;
  end

  always @(posedge clk) begin
    if (reset) begin
      phase_reg <= 8'h00;
      duty_reg <= 8'h00;
      fade_reg <= 8'h00;
      fadeUp_reg <= 1'b1;
      blink_reg <= 1'b0;
      pwmOut <= 1'b0;
    end else begin
      phase_reg <= phase_reg + 8'h01;
      if (phase_reg == 8'hFF)
        duty_reg <= target;
      // all ones keeps output on for the full period
      pwmOut <= (duty_reg == 8'hFF) | (phase_reg < duty_reg);
      if (stepTick) begin
        blink_reg <= ~blink_reg;
        if (fadeUp_reg) begin
          if (fade_reg == 8'hFF)
            fadeUp_reg <= 1'b0;
          else
            fade_reg <= fade_reg + 8'h01;
        end else begin
          if (fade_reg == 8'h00)
            fadeUp_reg <= 1'b1;
          else
            fade_reg <= fade_reg - 8'h01;
        end
      end
    end
  end
endmodule // led_pwm_channel

/* File: led_gpio_expander.v */
// Purpose: six-channel io controller: gpio, led dimming, breathing, irq
// Assumes: inputs synchronous to clk; bus slave decode done by word port
// Notes: serial bus front end lives outside; this block only supplies its address
//
// Functional notes
// - after reset all six ios are general-purpose outputs
// - power-up output levels come from the two address straps
// - both straps high give high or released outputs, leds off
// - each io independently selects led or general-purpose mode
// - each general-purpose io independently input or output
// - input changes accepted only after 8 us of stability
// - accepted change on an input asserts interrupt
// - reading input state releases interrupt; host must read it
// - interrupt is active low open-drain
// - led level sets drive linearly in 256 steps
// - full-scale current defaults to 37 mA, changeable in global control
// - device answers one of four bus addresses chosen by straps
// - device held in reset while reset pin is low
// - shutdown held while active-low shutdown is asserted
// - first four ios drive push-pull as outputs
// - last two ios open-drain by default, push-pull selectable
// - blink and fade breathing effects with adjustable period
// - dim level all ones gives full-scale current
//
// Local design decisions: the address map and the strobed register port.
`include "led_gpio_defs.vh"
module led_gpio_expander #(
  parameter [4:0] ADDR_UPPER = 5'h0B,
  // output levels per strap code {hi,lo}: 00,01,10,11
  parameter [23:0] STRAP_TABLE = 24'hFC0_03F
) (
  input wire clk,
  input wire reset,
  input wire hwResetLow,
  input wire shutdownLow,
  input wire addrStrapLo,
  input wire addrStrapHi,
  input wire [3:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWrite,
  input wire regRead,
  output reg [7:0] regRdData,
  input wire [5:0] ioIn,
  output reg [5:0] ioOut,
  output reg [5:0] ioOutEnLow,
  output reg [5:0] ledDrive,
  output reg [1:0] fullScaleCurrent,
  output reg [6:0] busAddress,
  output reg irqLowOut,
  output reg irqLowOutEnLow,
  output reg lowPower
);
  wire resetAll = reset | ~hwResetLow;

  reg [5:0] outLevel_reg;
  reg [5:0] dirIn_reg;
  reg [5:0] ledMode_reg;
  reg [7:0] global_reg;
  reg [5:0] breathEn_reg;
  reg [5:0] breathSel_reg;
  reg [7:0] breathPer_reg;
  reg [47:0] dim_reg;
  reg [5:0] lastIn_reg;
  reg irqPend_reg;
  reg strapCaught_reg;
  reg [1:0] strap_reg;
  reg [`BREATH_PRE_W-1:0] pre_reg;
  reg [7:0] perCnt_reg;
  reg stepTick_reg;
  wire [5:0] filtered;
  wire [5:0] pwm;
  wire [5:0] changed = (filtered ^ lastIn_reg) & dirIn_reg & ~ledMode_reg;
  wire readInput = regRead && (regAddr == `REG_INPUT);

  // strap table lookup, used only for the power-up output levels
  function [5:0] strapLevels;
    input [1:0] code;
    begin
      strapLevels = STRAP_TABLE[code*6 +: 6];
    end
  endfunction

  genvar gi;
  generate
    for (gi = 0; gi < `NUM_IO; gi = gi + 1) begin : chan
      deglitch_filter filt (
        .clk(clk),
        .reset(resetAll),
        .rawIn(ioIn[gi]),
        .initLevel(1'b0),
        .stableOut(filtered[gi])
      );
      led_pwm_channel pwmCh (
        .clk(clk),
        .reset(resetAll),
        .dimLevel(dim_reg[gi*8 +: 8]),
        .breathEn(breathEn_reg[gi]),
        .breathSel(breathSel_reg[gi]),
        .stepTick(stepTick_reg),
        .pwmOut(pwm[gi])
      );
    end
  endgenerate

  // straps caught by a clocked process in the first cycle after release
  always @(posedge clk) begin
    if (resetAll) begin
      strapCaught_reg <= 1'b0;
      strap_reg <= 2'b11;
    end else if (!strapCaught_reg) begin
      strapCaught_reg <= 1'b1;
      strap_reg <= {addrStrapHi, addrStrapLo};
    end
  end

  // breathing step tick: period register scales a fixed prescaler
  always @(posedge clk) begin
    if (resetAll) begin
      pre_reg <= {`BREATH_PRE_W{1'b0}};
      perCnt_reg <= 8'h00;
      stepTick_reg <= 1'b0;
    end else begin
      pre_reg <= pre_reg + 1'b1;
      stepTick_reg <= 1'b0;
      if (&pre_reg) begin
        if (perCnt_reg >= breathPer_reg) begin
          perCnt_reg <= 8'h00;
          stepTick_reg <= 1'b1;
        end else begin
          perCnt_reg <= perCnt_reg + 8'h01;
        end
      end
    end
  end

  // register writes and interrupt tracking
  always @(posedge clk) begin
    if (resetAll) begin
      outLevel_reg <= `RST_PINS; // safe until straps are caught
      dirIn_reg <= `RST_DIR;
      ledMode_reg <= `RST_MODE;
      global_reg <= `RST_GLOBAL;
      breathEn_reg <= 6'h00;
      breathSel_reg <= 6'h00;
      breathPer_reg <= `RST_BREATH_PER;
      dim_reg <= {6{`RST_DIM}};
      lastIn_reg <= 6'h00;
      irqPend_reg <= 1'b0;
    end else begin
      if (!strapCaught_reg)
        outLevel_reg <= strapLevels({addrStrapHi, addrStrapLo});
      lastIn_reg <= filtered;
      // a new change in the clearing read cycle wins over the clear
      if (|changed)
        irqPend_reg <= 1'b1;
      else if (readInput)
        irqPend_reg <= 1'b0;
      if (regWrite) begin
        case (regAddr)
          `REG_OUTPUT: outLevel_reg <= regWrData[5:0];
          `REG_DIR: dirIn_reg <= regWrData[5:0];
          `REG_MODE: ledMode_reg <= regWrData[5:0];
          `REG_GLOBAL: global_reg <= regWrData;
          `REG_BREATH_EN: breathEn_reg <= regWrData[5:0];
          `REG_BREATH_SEL: breathSel_reg <= regWrData[5:0];
          `REG_BREATH_PER: breathPer_reg <= regWrData;
          default: begin
            if (regAddr >= `REG_DIM_BASE && regAddr < `REG_DIM_BASE + 4'h6)
              dim_reg[(regAddr - `REG_DIM_BASE)*8 +: 8] <= regWrData;
          end
        endcase
      end
    end
  end

  // read port: data valid the cycle after the strobe
  always @(posedge clk) begin
    if (resetAll) begin
      regRdData <= 8'h00;
    end else if (regRead) begin
      case (regAddr)
        `REG_INPUT: regRdData <= {2'b00, filtered};
        `REG_OUTPUT: regRdData <= {2'b00, outLevel_reg};
        `REG_DIR: regRdData <= {2'b00, dirIn_reg};
        `REG_MODE: regRdData <= {2'b00, ledMode_reg};
        `REG_GLOBAL: regRdData <= global_reg;
        `REG_BREATH_EN: regRdData <= {2'b00, breathEn_reg};
        `REG_BREATH_SEL: regRdData <= {2'b00, breathSel_reg};
        `REG_BREATH_PER: regRdData <= breathPer_reg;
        `REG_ADDR: regRdData <= {1'b0, busAddress};
        default: begin
          if (regAddr >= `REG_DIM_BASE && regAddr < `REG_DIM_BASE + 4'h6)
            regRdData <= dim_reg[(regAddr - `REG_DIM_BASE)*8 +: 8];
          else
            regRdData <= 8'h00;
        end
      endcase
    end else begin
      regRdData <= 8'h00;
    end
  end

  // pin drivers: registered so every output comes from a flip-flop
  integer i;
  always @(posedge clk) begin
    if (resetAll) begin
      ioOut <= `RST_PINS;
      ioOutEnLow <= `RST_PINS;
      ledDrive <= 6'h00;
      fullScaleCurrent <= 2'b00;
      busAddress <= {ADDR_UPPER, 2'b11};
      irqLowOut <= 1'b0;
      irqLowOutEnLow <= 1'b1;
      lowPower <= 1'b1;
    end else begin
      busAddress <= {ADDR_UPPER, strap_reg};
      fullScaleCurrent <= global_reg[`GLB_FULL_SCALE_CURRENT_LSB +: `GLB_FULL_SCALE_CURRENT_W];
      lowPower <= ~shutdownLow;
      irqLowOut <= 1'b0;
      irqLowOutEnLow <= ~irqPend_reg;
      for (i = 0; i < `NUM_IO; i = i + 1) begin
        ledDrive[i] <= ledMode_reg[i] & pwm[i] & shutdownLow;
        ioOut[i] <= outLevel_reg[i];
        if (ledMode_reg[i] || dirIn_reg[i] || !shutdownLow)
          ioOutEnLow[i] <= 1'b1;
        else if (i < 4)
          ioOutEnLow[i] <= 1'b0;
        else if (global_reg[`GLB_PP_BIT])
          ioOutEnLow[i] <= 1'b0;
        else
          ioOutEnLow[i] <= outLevel_reg[i];
      end
    end
  end
endmodule // led_gpio_expander

/* File: led_gpio_expander_properties.sv */
// Purpose: port properties of the led/gpio expander
// Assumes: one clock; reset and hwResetLow both reset the block
// Notes: bound below to every instance of the top module
module led_gpio_expander_properties #(
  parameter [4:0] ADDR_UPPER = 5'h0B
) (
  input wire clk,
  input wire reset,
  input wire hwResetLow,
  input wire shutdownLow,
  input wire [3:0] regAddr,
  input wire regRead,
  input wire [5:0] ioOutEnLow,
  input wire [5:0] ledDrive,
  input wire [6:0] busAddress,
  input wire irqLowOut,
  input wire irqLowOutEnLow,
  input wire lowPower
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] runCnt;
  logic inRead;
  logic inReadLast;
  default clocking @(posedge clk); endclocking
  default disable iff (reset || !hwResetLow);
  assign inRead = regRead && regAddr == 4'h0;
  // cycles since release, saturating; a read of the inputs is remembered one cycle
  always @(posedge clk) begin
    inReadLast <= inRead;
    if (reset || !hwResetLow) runCnt <= 2'h0;
    else if (runCnt != 2'h3) runCnt <= runCnt + 2'h1;
  end
  a_reset_state: assert property (disable iff (1'b0)
    (reset || !hwResetLow) |=> ioOutEnLow == 6'h3F && ledDrive == 6'h00
      && irqLowOutEnLow && lowPower) else $error("outputs not released in reset");
  a_irq_pin_low: assert property (irqLowOut == 1'b0)
    else $error("interrupt pin drives high");
  a_read_clears_irq: assert property (inRead |-> ##2 irqLowOutEnLow)
    else $error("interrupt not released after input read");
  a_irq_holds: assert property (
    !irqLowOutEnLow && shutdownLow && !inRead && !inReadLast |=> !irqLowOutEnLow)
    else $error("interrupt dropped without a read");
  a_shutdown_dark: assert property (!shutdownLow |=> lowPower && ledDrive == 6'h00)
    else $error("drive left on in shutdown");
  a_wake_up: assert property (runCnt != 2'h0 && shutdownLow ##1 shutdownLow |-> !lowPower)
    else $error("low power without shutdown");
  a_addr_upper: assert property (runCnt != 2'h0 |-> busAddress[6:2] == ADDR_UPPER)
    else $error("upper address bits wrong");
  a_straps_held: assert property (runCnt == 2'h3 |-> $stable(busAddress))
    else $error("bus address moved after power-up");
  a_gpio_driven: assert property (runCnt == 2'h2 |-> ioOutEnLow[3:0] == 4'h0)
    else $error("outputs not driven after release");
endmodule // led_gpio_expander_properties

bind led_gpio_expander led_gpio_expander_properties #(.ADDR_UPPER(ADDR_UPPER))
  i_led_gpio_expander_properties (.clk(clk), .reset(reset), .hwResetLow(hwResetLow),
  .shutdownLow(shutdownLow), .regAddr(regAddr), .regRead(regRead),
  .ioOutEnLow(ioOutEnLow), .ledDrive(ledDrive), .busAddress(busAddress),
  .irqLowOut(irqLowOut), .irqLowOutEnLow(irqLowOutEnLow), .lowPower(lowPower));

/* File: led_pin_env.sv */
// Purpose: board around the expander pins: pads, pull-ups, interrupt line
// Assumes: extLevel is what the outside world puts on a released pad
// Notes: a released pad never keeps the block's last driven level
module led_pin_env (
  input wire logic [5:0] ioOut,
  input wire logic [5:0] ioOutEnLow,
  input wire logic [5:0] extLevel,
  input wire logic irqLowOut,
  input wire logic irqLowOutEnLow,
  output logic [5:0] ioPad,
  output logic irqLine
);
  timeunit 1ns;
  timeprecision 1ps;
  // pad level: block drive where enabled, outside level otherwise
  always_comb begin
    for (int i = 0; i < 6; i++) ioPad[i] = ioOutEnLow[i] ? extLevel[i] : ioOut[i];
    irqLine = irqLowOutEnLow ? 1'b1 : irqLowOut;
  end
endmodule // led_pin_env

/* File: led_gpio_expander_tb_top.sv */
// Purpose: self-checking bench for the led/gpio expander
// Assumes: register strobes change right after rising edges
// Notes: breathing runs one blink step, which takes 65536 clocks at the shortest period
`include "led_gpio_defs.vh"
module led_gpio_expander_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam [4:0] UPPER = 5'h0B;
  logic clk, reset, hwResetLow, shutdownLow, addrStrapLo, addrStrapHi, regWrite, regRead;
  logic irqLowOut, irqLowOutEnLow, lowPower, irqLine;
  logic [3:0] regAddr;
  logic [7:0] regWrData, regRdData, rdVal;
  logic [5:0] ioIn, ioOut, ioOutEnLow, ledDrive, extLevel;
  logic [1:0] fullScaleCurrent;
  logic [6:0] busAddress;
  int nErrors, checked, cycles, cnt;

  led_gpio_expander #(.ADDR_UPPER(UPPER)) i_led_gpio_expander (.clk(clk), .reset(reset),
    .hwResetLow(hwResetLow), .shutdownLow(shutdownLow), .addrStrapLo(addrStrapLo),
    .addrStrapHi(addrStrapHi), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .ioIn(ioIn),
    .ioOut(ioOut), .ioOutEnLow(ioOutEnLow), .ledDrive(ledDrive),
    .fullScaleCurrent(fullScaleCurrent), .busAddress(busAddress), .irqLowOut(irqLowOut),
    .irqLowOutEnLow(irqLowOutEnLow), .lowPower(lowPower));
  led_pin_env i_led_pin_env (.ioOut(ioOut), .ioOutEnLow(ioOutEnLow), .extLevel(extLevel),
    .irqLowOut(irqLowOut), .irqLowOutEnLow(irqLowOutEnLow), .ioPad(ioIn), .irqLine(irqLine));

  // 50 MHz clock
  always #10 clk = ~clk;

  // hang guard: about 6k cycles of tests plus at most 77k for the blink step
  always @(posedge clk) begin
    cycles++;
    if (cycles == 90000) begin
      nErrors++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checked, nErrors);
    if (nErrors == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      nErrors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1 rdVal = regRdData;
  endtask

  task automatic do_reset(input logic hi, input logic lo, input logic viaPin);
    addrStrapHi <= hi;
    addrStrapLo <= lo;
    if (viaPin) hwResetLow <= 1'b0;
    else reset <= 1'b1;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    hwResetLow <= 1'b1;
    settle(3);
  endtask

  task automatic count_led(input int n);
    cnt = 0;
    repeat (n) begin
      @(posedge clk);
      #1 cnt += ledDrive[0];
    end
  endtask

  task automatic t_power_up();
    do_reset(1'b1, 1'b1, 1'b0);
    chk("ioOut 11", 16'h003F, ioOut);
    chk("enLow", 16'h0000, ioOutEnLow[3:0]);
    chk("addr 11", {UPPER, 2'h3}, busAddress);
    chk("current", 16'h0000, fullScaleCurrent);
    rd(`REG_MODE);
    chk("mode", 16'h0000, rdVal);
    rd(4'hF);
    chk("unmapped", 16'h0000, rdVal);
    rd(`REG_ADDR);
    chk("addr reg", {UPPER, 2'h3}, rdVal);
    // pin reset starts on a rising edge like every other stimulus
    @(posedge clk);
    do_reset(1'b0, 1'b1, 1'b1);
    chk("ioOut 01", 16'h0000, ioOut);
    chk("enLow 01", 16'h0000, ioOutEnLow);
    chk("addr 01", {UPPER, 2'h1}, busAddress);
    $display("test power_up done");
  endtask

  task automatic t_gpio_drive();
    wr(`REG_DIR, 8'h0F);
    wr(`REG_OUTPUT, 8'h30);
    settle(3);
    chk("enLow od", 16'h003F, ioOutEnLow);
    wr(`REG_GLOBAL, 8'h04);
    settle(3);
    chk("enLow pp", 16'h000F, ioOutEnLow);
    wr(`REG_DIR, 8'h00);
    wr(`REG_OUTPUT, 8'h05);
    settle(3);
    chk("out", 16'h0005, ioOut);
    chk("enLow all", 16'h0000, ioOutEnLow);
    $display("test gpio_drive done");
  endtask

  task automatic t_irq();
    wr(`REG_DIR, 8'h0F);
    settle(420);
    rd(`REG_INPUT);
    settle(3);
    chk("irq idle", 16'h0001, irqLine);
    @(posedge clk);
    extLevel[1] <= 1'b0;
    settle(100);
    @(posedge clk);
    extLevel[1] <= 1'b1;
    settle(500);
    chk("irq glitch", 16'h0001, irqLine);
    @(posedge clk);
    extLevel[1] <= 1'b0;
    settle(398);
    chk("irq early", 16'h0001, irqLine);
    settle(28);
    chk("irq set", 16'h0000, irqLine);
    rd(`REG_INPUT);
    chk("inputs", 16'h000D, rdVal[3:0]);
    settle(2);
    chk("irq clear", 16'h0001, irqLine);
    $display("test irq done");
  endtask

  task automatic t_led();
    wr(`REG_MODE, 8'h01);
    wr(`REG_DIM_BASE, 8'hFF);
    settle(520);
    count_led(512);
    chk("dim full", 16'h0200, cnt);
    wr(`REG_DIM_BASE, 8'h40);
    settle(520);
    count_led(1024);
    chk("dim quarter", 16'h0001, cnt >= 248 && cnt <= 264);
    wr(`REG_DIM_BASE, 8'h00);
    settle(520);
    count_led(512);
    chk("dim zero", 16'h0000, cnt);
    wr(`REG_GLOBAL, 8'h02);
    rd(`REG_GLOBAL);
    chk("global", 16'h0002, rdVal);
    chk("current", 16'h0002, fullScaleCurrent);
    @(posedge clk);
    shutdownLow <= 1'b0;
    settle(3);
    chk("lowPower", 16'h0001, lowPower);
    @(posedge clk);
    shutdownLow <= 1'b1;
    settle(3);
    chk("awake", 16'h0000, lowPower);
    $display("test led done");
  endtask

  // blink at the shortest period: one step per 65536 clocks, so within two
  // steps the led must show a fully dark and a fully lit window
  task automatic t_breath();
    logic sawOn;
    logic sawOff;
    int n;
    sawOn = 1'b0;
    sawOff = 1'b0;
    n = 0;
    wr(`REG_BREATH_PER, 8'h00);
    wr(`REG_BREATH_SEL, 8'h00);
    wr(`REG_BREATH_EN, 8'h01);
    wr(`REG_DIM_BASE, 8'hFF);
    settle(520);
    while (!(sawOn && sawOff) && n < 300) begin
      count_led(256);
      if (cnt == 256) sawOn = 1'b1;
      if (cnt == 0) sawOff = 1'b1;
      n++;
    end
    chk("blink dark", 16'h0001, sawOff);
    chk("blink lit", 16'h0001, sawOn);
    $display("test breath done");
  endtask

  initial begin
    clk = 1'b0;
    reset = 1'b1;
    hwResetLow = 1'b1;
    shutdownLow = 1'b1;
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 4'h0;
    regWrData = 8'h00;
    extLevel = 6'h3F;
    t_power_up();
    t_gpio_drive();
    t_irq();
    t_led();
    t_breath();
    complete_run();
  end
endmodule // led_gpio_expander_tb_top
